// *** rmpc_pkg.sv ***
// Summary of operation
// [RULE1] sample clock, debug, bus-fault selects at reset
// [RULE2] board drives the three selects during reset
// [RULE3] fault high, DATA1 low: 16-bit expanded
// [RULE4] 16-bit mode offers no ports A/B/G/H
// [RULE5] fault high, DATA1 high: 8-bit, port H
// [RULE6] 8-bit mode: upper data byte is bus
// [RULE7] 8-bit mode: address lines stay address outputs
// [RULE8] 8-bit mode: emulator mode always disabled
// [RULE9] single-chip: no bus, ports A/B/G/H
// [RULE10] expanded: latched data lines pick pin functions
// [RULE11] software may later rewrite pin assignments
// [RULE12] board pulls data line low for alternate
// [RULE13] 16-bit: boot width, bus request, ports E/F
// [RULE14] 16-bit: low lines add upper address pins
// [RULE15] emulator select needs DATA10 and DATA1 low
// [RULE16] ROM emulation select needs DATA13/10/1 low
// [RULE17] DATA11 low enables factory slave mode; code enables it only in the expanded modes
// [RULE18] 8-bit: boot 8-bit, fixed selects, E/F chosen
// [RULE19] read-only slave status follows latched DATA11; code holds it low in single-chip mode
// [RULE20] capture at reset release, hold until reset
package rmpc_pkg;

    // data lines sampled at reset
    localparam int DATA_W            = 16;
    // positions of the configuration selects on the data lines
    localparam int SEL_BOOT_8BIT     = 0;
    localparam int SEL_MODE_WIDTH    = 1;
    localparam int SEL_BUS_REQUEST   = 2;
    localparam int SEL_UPPER_ADDR_LO = 3;
    localparam int UPPER_ADDR_W      = 5;
    localparam int SEL_PORT_E        = 8;
    localparam int SEL_PORT_F        = 9;
    localparam int SEL_EMULATOR      = 10;
    localparam int SEL_SLAVE         = 11;
    localparam int SEL_ROM_EMU       = 13;
    // positions inside the synchronised pin vector
    localparam int PIN_CLK_SRC       = 16;
    localparam int PIN_DEBUG         = 17;
    localparam int PIN_BUS_FAULT     = 18;
    localparam int PIN_W             = 19;
    // pin assignment register width and values
    localparam int ASSIGN_W          = 8;
    localparam logic [ASSIGN_W-1:0] ASSIGN_ALL_PORT = 8'hff;
    localparam logic [ASSIGN_W-1:0] ASSIGN_ALL_BUS  = 8'h00;
    // reset values of the configuration outputs
    localparam logic [ASSIGN_W-1:0]     RST_ASSIGN     = 8'h00;
    localparam logic [UPPER_ADDR_W-1:0] RST_UPPER_ADDR = 5'h00;
    localparam logic                    RST_FLAG       = 1'b0;

    // operating modes
    typedef enum logic [1:0] {
        MODE_SINGLE,
        MODE_EXP8,
        MODE_EXP16
    } rmpc_mode_t;

    // a low line turns its own and every lower upper line into address
    function automatic logic [UPPER_ADDR_W-1:0] rmpc_upper_addr_mask(
        input logic [UPPER_ADDR_W-1:0] selLevels
    );
        logic [UPPER_ADDR_W-1:0] mask;
        logic                    anyLow;
        mask   = RST_UPPER_ADDR;
        anyLow = 1'b0;
        for (int i = UPPER_ADDR_W - 1; i >= 0; i--) begin
            anyLow  = anyLow | ~selLevels[i];
            mask[i] = anyLow;
        end
        return mask;
    endfunction

endpackage

// *** rmpc_pin_sync.sv ***
`timescale 1ns/1ps
// two-stage synchroniser for the reset select pins
module rmpc_pin_sync (
    input  wire logic                       core_clk,
    input  wire logic                       clkEn,
    input  wire logic [rmpc_pkg::PIN_W-1:0] pinAsync,
    output logic      [rmpc_pkg::PIN_W-1:0] pinSync
);
    // no reset here on purpose: the stages must keep sampling while
    // reset is held so the levels are ready at its release
    logic [rmpc_pkg::PIN_W-1:0] stageOne;  // metastability stage, read only by stage two
    logic [rmpc_pkg::PIN_W-1:0] stageTwo;  // settled copy

    genvar g;
    generate
        for (g = 0; g < rmpc_pkg::PIN_W; g++) begin : gSync
            // one pair of flops per pin
            always_ff @(posedge core_clk) begin
                if (clkEn) begin
                    stageOne[g] <= pinAsync[g];
                    stageTwo[g] <= stageOne[g];
                end
            end
        end
    endgenerate

    assign pinSync = stageTwo;
endmodule

// *** rmpc_mode_decode.sv ***
`timescale 1ns/1ps
// combinational map from sampled select levels to pin functions
module rmpc_mode_decode (
    input  wire logic [rmpc_pkg::PIN_W-1:0]        pinLevels,
    output rmpc_pkg::rmpc_mode_t                   modeD,
    output logic                                   clockIsSynthD,
    output logic                                   backgroundEnD,
    output logic                                   addrBusEnD,
    output logic                                   dataHiBusEnD,
    output logic                                   dataLoBusEnD,
    output logic                                   portAEnD,
    output logic                                   portBEnD,
    output logic                                   portGEnD,
    output logic                                   portHEnD,
    output logic                                   bootCs8BitD,
    output logic                                   busRequestEnD,
    output logic      [rmpc_pkg::UPPER_ADDR_W-1:0] upperAddrEnD,
    output logic      [rmpc_pkg::ASSIGN_W-1:0]     portEAssignD,
    output logic      [rmpc_pkg::ASSIGN_W-1:0]     portFAssignD,
    output logic                                   emulatorSelEnD,
    output logic                                   romEmuSelEnD,
    output logic                                   slaveModeEnD
);
    // named views of the pin vector
    wire logic [rmpc_pkg::DATA_W-1:0] data     = pinLevels[rmpc_pkg::DATA_W-1:0];
    wire logic                        busFault = pinLevels[rmpc_pkg::PIN_BUS_FAULT];
    // mode qualifiers
    wire logic isExp  = busFault;                                    // RULE1
    wire logic is16   = busFault & ~data[rmpc_pkg::SEL_MODE_WIDTH];  // RULE3
    wire logic is8    = busFault & data[rmpc_pkg::SEL_MODE_WIDTH];   // RULE5

    // mode selection, single-chip wins when the fault line is low
    assign modeD = !isExp ? rmpc_pkg::MODE_SINGLE :
                   (is8 ? rmpc_pkg::MODE_EXP8 : rmpc_pkg::MODE_EXP16);
    // clock source and debug: high means synthesized, low means debug on
    assign clockIsSynthD = pinLevels[rmpc_pkg::PIN_CLK_SRC];  // RULE1
    assign backgroundEnD = ~pinLevels[rmpc_pkg::PIN_DEBUG];   // RULE1
    // bus and port ownership of address and data pins
    assign addrBusEnD   = isExp;   // RULE3 RULE7
    assign dataHiBusEnD = isExp;   // RULE6
    assign dataLoBusEnD = is16;    // RULE3
    assign portAEnD     = ~isExp;  // RULE4 RULE9
    assign portBEnD     = ~isExp;  // RULE4 RULE9
    assign portGEnD     = ~isExp;  // RULE4 RULE9
    assign portHEnD     = ~is16;   // RULE5 RULE9
    // boot select width only selectable in 16-bit mode
    assign bootCs8BitD   = ~is16 | ~data[rmpc_pkg::SEL_BOOT_8BIT];   // RULE13 RULE18
    assign busRequestEnD = is16 & ~data[rmpc_pkg::SEL_BUS_REQUEST];  // RULE13 RULE18
    // extra address lines replace chip selects only in 16-bit mode
    assign upperAddrEnD = is16 ?
        rmpc_pkg::rmpc_upper_addr_mask(data[rmpc_pkg::SEL_UPPER_ADDR_LO +: rmpc_pkg::UPPER_ADDR_W]) :
        rmpc_pkg::RST_UPPER_ADDR;  // RULE14
    // ports E and F: chosen by data lines when expanded, always in single-chip
    assign portEAssignD = (~isExp | ~data[rmpc_pkg::SEL_PORT_E]) ?
        rmpc_pkg::ASSIGN_ALL_PORT : rmpc_pkg::ASSIGN_ALL_BUS;  // RULE10 RULE13 RULE18
    assign portFAssignD = (~isExp | ~data[rmpc_pkg::SEL_PORT_F]) ?
        rmpc_pkg::ASSIGN_ALL_PORT : rmpc_pkg::ASSIGN_ALL_BUS;  // RULE10 RULE13 RULE18
    // emulation selects exist only in 16-bit expanded mode
    assign emulatorSelEnD = is16 & ~data[rmpc_pkg::SEL_EMULATOR];        // RULE8 RULE15
    assign romEmuSelEnD   = emulatorSelEnD & ~data[rmpc_pkg::SEL_ROM_EMU];  // RULE16
    // slave mode only reachable in an expanded mode
    assign slaveModeEnD   = isExp & ~data[rmpc_pkg::SEL_SLAVE];          // RULE17
endmodule

// *** rmpc_top.sv ***
`timescale 1ns/1ps
// reset-time mode and pin configuration capture
module rmpc_top (
    input  wire logic                                   core_clk,
    input  wire logic                                   rst_b,
    input  wire logic                                   clkEn,
    input  wire logic                                   clockSourceSelectPin,
    input  wire logic                                   debugModeSelectPin,
    input  wire logic                                   busFaultLinePin,
    input  wire logic      [rmpc_pkg::DATA_W-1:0]       dataPins,
    input  wire logic                                   swPortEWr,
    input  wire logic      [rmpc_pkg::ASSIGN_W-1:0]     swPortEData,
    input  wire logic                                   swPortFWr,
    input  wire logic      [rmpc_pkg::ASSIGN_W-1:0]     swPortFData,
    output rmpc_pkg::rmpc_mode_t                        operatingMode,
    output logic                                        configValid,
    output logic                                        clockIsSynth,
    output logic                                        backgroundModeEn,
    output logic                                        addrBusEn,
    output logic                                        dataHiBusEn,
    output logic                                        dataLoBusEn,
    output logic                                        portAEn,
    output logic                                        portBEn,
    output logic                                        portGEn,
    output logic                                        portHEn,
    output logic                                        bootChipSelect8Bit,
    output logic                                        busRequestLineEn,
    output logic           [rmpc_pkg::UPPER_ADDR_W-1:0] upperAddrEn,
    output logic           [rmpc_pkg::ASSIGN_W-1:0]     portEAssign,
    output logic           [rmpc_pkg::ASSIGN_W-1:0]     portFAssign,
    output logic                                        emulatorSelectEn,
    output logic                                        romEmulationSelectEn,
    output logic                                        slaveModeEn,
    output logic                                        slaveEnableStatus
);

    // synchronised pin levels
    logic [rmpc_pkg::PIN_W-1:0] pinSync;

    // decoded next values, only loaded at capture
    rmpc_pkg::rmpc_mode_t              modeD;
    logic                              clockIsSynthD;
    logic                              backgroundEnD;
    logic                              addrBusEnD;
    logic                              dataHiBusEnD;
    logic                              dataLoBusEnD;
    logic                              portAEnD;
    logic                              portBEnD;
    logic                              portGEnD;
    logic                              portHEnD;
    logic                              bootCs8BitD;
    logic                              busRequestEnD;
    logic [rmpc_pkg::UPPER_ADDR_W-1:0] upperAddrEnD;
    logic [rmpc_pkg::ASSIGN_W-1:0]     portEAssignD;
    logic [rmpc_pkg::ASSIGN_W-1:0]     portFAssignD;
    logic                              emulatorSelEnD;
    logic                              romEmuSelEnD;
    logic                              slaveModeEnD;

    // held configuration
    rmpc_pkg::rmpc_mode_t              mode_q;
    logic                              valid_q;
    logic                              clockIsSynth_q;
    logic                              backgroundEn_q;
    logic                              addrBusEn_q;
    logic                              dataHiBusEn_q;
    logic                              dataLoBusEn_q;
    logic                              portAEn_q;
    logic                              portBEn_q;
    logic                              portGEn_q;
    logic                              portHEn_q;
    logic                              bootCs8Bit_q;
    logic                              busRequestEn_q;
    logic [rmpc_pkg::UPPER_ADDR_W-1:0] upperAddrEn_q;
    logic [rmpc_pkg::ASSIGN_W-1:0]     portEAssign_q;
    logic [rmpc_pkg::ASSIGN_W-1:0]     portFAssign_q;
    logic [rmpc_pkg::ASSIGN_W-1:0]     portEAssign_d;
    logic [rmpc_pkg::ASSIGN_W-1:0]     portFAssign_d;
    logic                              emulatorSelEn_q;
    logic                              romEmuSelEn_q;
    logic                              slaveModeEn_q;
    logic                              slaveStatus_q;

    // the selects have no internal default, so the board must hold them
    // for the whole of reset; the synchroniser keeps sampling meanwhile
    rmpc_pin_sync uSync (
        .core_clk (core_clk),
        .clkEn    (clkEn),
        .pinAsync ({busFaultLinePin, debugModeSelectPin, clockSourceSelectPin, dataPins}),  // RULE2 RULE12
        .pinSync  (pinSync)
    );

    // pure decode, kept apart so the capture stays one flop stage
    rmpc_mode_decode uDecode (
        .pinLevels      (pinSync),
        .modeD          (modeD),
        .clockIsSynthD  (clockIsSynthD),
        .backgroundEnD  (backgroundEnD),
        .addrBusEnD     (addrBusEnD),
        .dataHiBusEnD   (dataHiBusEnD),
        .dataLoBusEnD   (dataLoBusEnD),
        .portAEnD       (portAEnD),
        .portBEnD       (portBEnD),
        .portGEnD       (portGEnD),
        .portHEnD       (portHEnD),
        .bootCs8BitD    (bootCs8BitD),
        .busRequestEnD  (busRequestEnD),
        .upperAddrEnD   (upperAddrEnD),
        .portEAssignD   (portEAssignD),
        .portFAssignD   (portFAssignD),
        .emulatorSelEnD (emulatorSelEnD),
        .romEmuSelEnD   (romEmuSelEnD),
        .slaveModeEnD   (slaveModeEnD)
    );

    // capture strobe: first enabled edge after reset lets go
    wire logic captureNow = clkEn & ~valid_q;  // RULE20
    // software writes only count once the reset picture is held
    wire logic portEWrOk  = clkEn & valid_q & swPortEWr;  // RULE11
    wire logic portFWrOk  = clkEn & valid_q & swPortFWr;  // RULE11

    // pin assignment next values: capture, then software, else hold
    assign portEAssign_d = captureNow ? portEAssignD :
                           (portEWrOk ? swPortEData : portEAssign_q);  // RULE10 RULE11
    assign portFAssign_d = captureNow ? portFAssignD :
                           (portFWrOk ? swPortFData : portFAssign_q);  // RULE10 RULE11

    // valid flag never drops until the next reset
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            valid_q <= rmpc_pkg::RST_FLAG;
        end else if (captureNow) begin
            valid_q <= 1'b1;  // RULE20
        end
    end

    // mode, clock and debug selection
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_q         <= rmpc_pkg::MODE_SINGLE;
            clockIsSynth_q <= rmpc_pkg::RST_FLAG;
            backgroundEn_q <= rmpc_pkg::RST_FLAG;
        end else if (captureNow) begin
            mode_q         <= modeD;          // RULE3 RULE5 RULE9
            clockIsSynth_q <= clockIsSynthD;  // RULE1
            backgroundEn_q <= backgroundEnD;  // RULE1
        end
    end

    // address and data bus versus port ownership
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            addrBusEn_q   <= rmpc_pkg::RST_FLAG;
            dataHiBusEn_q <= rmpc_pkg::RST_FLAG;
            dataLoBusEn_q <= rmpc_pkg::RST_FLAG;
            portAEn_q     <= rmpc_pkg::RST_FLAG;
            portBEn_q     <= rmpc_pkg::RST_FLAG;
            portGEn_q     <= rmpc_pkg::RST_FLAG;
            portHEn_q     <= rmpc_pkg::RST_FLAG;
        end else if (captureNow) begin
            addrBusEn_q   <= addrBusEnD;    // RULE7
            dataHiBusEn_q <= dataHiBusEnD;  // RULE6
            dataLoBusEn_q <= dataLoBusEnD;  // RULE3
            portAEn_q     <= portAEnD;      // RULE9
            portBEn_q     <= portBEnD;      // RULE9
            portGEn_q     <= portGEnD;      // RULE9
            portHEn_q     <= portHEnD;      // RULE5
        end
    end

    // chip-select area functions
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bootCs8Bit_q   <= rmpc_pkg::RST_FLAG;
            busRequestEn_q <= rmpc_pkg::RST_FLAG;
            upperAddrEn_q  <= rmpc_pkg::RST_UPPER_ADDR;
        end else if (captureNow) begin
            bootCs8Bit_q   <= bootCs8BitD;    // RULE13 RULE18
            busRequestEn_q <= busRequestEnD;  // RULE13
            upperAddrEn_q  <= upperAddrEnD;   // RULE14
        end
    end

    // pin assignment registers: seeded at capture, writable after
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            portEAssign_q <= rmpc_pkg::RST_ASSIGN;
            portFAssign_q <= rmpc_pkg::RST_ASSIGN;
        end else if (clkEn) begin
            portEAssign_q <= portEAssign_d;  // RULE11
            portFAssign_q <= portFAssign_d;  // RULE11
        end
    end

    // emulation and factory slave mode
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            emulatorSelEn_q <= rmpc_pkg::RST_FLAG;
            romEmuSelEn_q   <= rmpc_pkg::RST_FLAG;
            slaveModeEn_q   <= rmpc_pkg::RST_FLAG;
            slaveStatus_q   <= rmpc_pkg::RST_FLAG;
        end else if (captureNow) begin
            emulatorSelEn_q <= emulatorSelEnD;  // RULE15
            romEmuSelEn_q   <= romEmuSelEnD;    // RULE16
            slaveModeEn_q   <= slaveModeEnD;    // RULE17
            slaveStatus_q   <= slaveModeEnD;    // RULE19
        end
    end

    // outputs straight from the holding flops
    assign operatingMode        = mode_q;
    assign configValid          = valid_q;
    assign clockIsSynth         = clockIsSynth_q;
    assign backgroundModeEn     = backgroundEn_q;
    assign addrBusEn            = addrBusEn_q;
    assign dataHiBusEn          = dataHiBusEn_q;
    assign dataLoBusEn          = dataLoBusEn_q;
    assign portAEn              = portAEn_q;
    assign portBEn              = portBEn_q;
    assign portGEn              = portGEn_q;
    assign portHEn              = portHEn_q;
    assign bootChipSelect8Bit   = bootCs8Bit_q;
    assign busRequestLineEn     = busRequestEn_q;
    assign upperAddrEn          = upperAddrEn_q;
    assign portEAssign          = portEAssign_q;
    assign portFAssign          = portFAssign_q;
    assign emulatorSelectEn     = emulatorSelEn_q;
    assign romEmulationSelectEn = romEmuSelEn_q;
    assign slaveModeEn          = slaveModeEn_q;
    assign slaveEnableStatus    = slaveStatus_q;

    // checks on the held configuration
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    // the capture step: not yet held, then held
    sequence captureSeq;
        !valid_q ##1 valid_q;
    endsequence

    // once held, stays held across several cycles
    sequence heldSeq;
        valid_q [*3];
    endsequence

    hold_stays_a: assert property (valid_q |=> valid_q)  // RULE20
        else $error("held configuration dropped without reset");

    mode_stable_a: assert property (heldSeq |-> $stable(mode_q) && $stable(upperAddrEn_q))  // RULE20
        else $error("mode changed after capture");

    select_sample_a: assert property (captureSeq |-> clockIsSynth_q == $past(pinSync[rmpc_pkg::PIN_CLK_SRC])
        && backgroundEn_q == !$past(pinSync[rmpc_pkg::PIN_DEBUG]))  // RULE1
        else $error("clock or debug select not taken from pins");

    mode_pick_a: assert property (captureSeq |-> (mode_q == rmpc_pkg::MODE_SINGLE)
        == !$past(pinSync[rmpc_pkg::PIN_BUS_FAULT]))  // RULE3
        else $error("mode does not follow bus fault line");

    wide_map_a: assert property (valid_q && mode_q == rmpc_pkg::MODE_EXP16 |->
        addrBusEn_q && dataHiBusEn_q && dataLoBusEn_q && !portAEn_q && !portBEn_q && !portGEn_q && !portHEn_q)  // RULE4
        else $error("16-bit mode pin map wrong");

    narrow_map_a: assert property (valid_q && mode_q == rmpc_pkg::MODE_EXP8 |->
        addrBusEn_q && dataHiBusEn_q && !dataLoBusEn_q && portHEn_q && bootCs8Bit_q
        && !busRequestEn_q && upperAddrEn_q == rmpc_pkg::RST_UPPER_ADDR)  // RULE6 RULE18
        else $error("8-bit mode pin map wrong");

    single_map_a: assert property (valid_q && mode_q == rmpc_pkg::MODE_SINGLE |->
        !addrBusEn_q && !dataHiBusEn_q && portAEn_q && portBEn_q && portGEn_q && portHEn_q)  // RULE9
        else $error("single-chip pin map wrong");

    emu_mode_a: assert property (valid_q && mode_q != rmpc_pkg::MODE_EXP16 |->
        !emulatorSelEn_q && !romEmuSelEn_q)  // RULE8
        else $error("emulation enabled outside 16-bit mode");

    emu_cause_a: assert property (captureSeq ##0 emulatorSelEn_q |->
        !$past(pinSync[rmpc_pkg::SEL_EMULATOR]) && !$past(pinSync[rmpc_pkg::SEL_MODE_WIDTH]))  // RULE15
        else $error("emulator select without both lines low");

    rom_emu_a: assert property (captureSeq ##0 romEmuSelEn_q |->
        emulatorSelEn_q && !$past(pinSync[rmpc_pkg::SEL_ROM_EMU]))  // RULE16
        else $error("rom emulation select without emulator conditions");

    slave_status_a: assert property (captureSeq |-> slaveStatus_q == slaveModeEn_q
        && slaveModeEn_q == (!$past(pinSync[rmpc_pkg::SEL_SLAVE]) && mode_q != rmpc_pkg::MODE_SINGLE))  // RULE17 RULE19
        else $error("slave status does not follow latched line");

    sw_write_a: assert property (valid_q && clkEn && swPortEWr |=> portEAssign_q == $past(swPortEData))  // RULE11
        else $error("port E assignment write lost");

endmodule

// *** rmpc_board_model.sv ***
`timescale 1ns/1ps
// board straps: drive the selects in reset, then let go
module rmpc_board_model (
    input  wire logic                       core_clk,
    input  wire logic                       rst_b,
    input  wire logic [rmpc_pkg::PIN_W-1:0] strap,
    output logic      [rmpc_pkg::PIN_W-1:0] pinOut
);
    logic [1:0] hold_q; // short hold past release covers the synchroniser
    // hold window restarts on every reset
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_q <= 2'h3;
        end else begin
            hold_q <= {hold_q[0], 1'b0};
        end
    end
    // data lines pull up; the selects float, so show them flipped
    always_comb begin
        if (!rst_b || hold_q[1]) begin
            pinOut = strap;
        end else begin
            pinOut = {~strap[18:16], 16'hffff};
        end
    end
endmodule

// *** tb.sv ***
`timescale 1ns/1ps
// self-checking bench for the reset-time pin configuration
module tb;
    logic core_clk, rst_b, swPortEWr, swPortFWr, configValid, clockIsSynth, backgroundModeEn, addrBusEn;
    logic dataHiBusEn, dataLoBusEn, portAEn, portBEn, portGEn, portHEn, bootChipSelect8Bit, busRequestLineEn;
    logic emulatorSelectEn, romEmulationSelectEn, slaveModeEn, slaveEnableStatus;
    logic [7:0]  swPortEData, swPortFData, portEAssign, portFAssign;
    logic [4:0]  upperAddrEn;
    logic [18:0] strap, pins;
    logic [38:0] seenV; // all outputs packed for one compare
    int          failures, checkCount;
    rmpc_pkg::rmpc_mode_t operatingMode;
    assign seenV = {operatingMode, configValid, clockIsSynth, backgroundModeEn, addrBusEn, dataHiBusEn,
        dataLoBusEn, portAEn, portBEn, portGEn, portHEn, bootChipSelect8Bit, busRequestLineEn, emulatorSelectEn,
        romEmulationSelectEn, slaveModeEn, slaveEnableStatus, upperAddrEn, portEAssign, portFAssign};
    rmpc_board_model u_board (.core_clk(core_clk), .rst_b(rst_b), .strap(strap), .pinOut(pins));
    rmpc_top u_dut (.core_clk, .rst_b, .clkEn(1'b1), .clockSourceSelectPin(pins[18]),
        .debugModeSelectPin(pins[17]), .busFaultLinePin(pins[16]), .dataPins(pins[15:0]), .swPortEWr,
        .swPortEData, .swPortFWr, .swPortFData, .operatingMode, .configValid, .clockIsSynth, .backgroundModeEn,
        .addrBusEn, .dataHiBusEn, .dataLoBusEn, .portAEn, .portBEn, .portGEn, .portHEn, .bootChipSelect8Bit,
        .busRequestLineEn, .upperAddrEn, .portEAssign, .portFAssign, .emulatorSelectEn, .romEmulationSelectEn,
        .slaveModeEn, .slaveEnableStatus);
    // expected outputs worked out from strap levels {clk, dbg, fault, data}
    function automatic logic [38:0] expect_of(input logic [18:0] s);
        logic e, e16;
        logic [4:0] up;
        logic [1:0] m;
        e = s[16];
        e16 = e & ~s[1];
        m = !e ? 2'h0 : (s[1] ? 2'h1 : 2'h2);
        for (int i = 0; i < 5; i++) up[i] = e16 & ((s[7:3] | ((5'h01 << i) - 5'h01)) != 5'h1f);
        return {m, 1'b1, s[18], ~s[17], e, e, e16, ~e, ~e, ~e, ~e16, ~e16 | ~s[0], e16 & ~s[2], e16 & ~s[10],
            e16 & ~s[10] & ~s[13], e & ~s[11], e & ~s[11], up, {8{~e | ~s[8]}}, {8{~e | ~s[9]}}};
    endfunction
    task check(input logic [38:0] seen, input logic [38:0] exp);
        checkCount++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    // reset with straps held, release, stop just after the capture edge
    task boot(input logic [18:0] s);
        @(posedge core_clk);
        strap <= s;
        rst_b <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        #1;
    endtask
    task t_single;
        boot(19'h40000);
        check(seenV, expect_of(19'h40000));
    endtask
    task t_wide;
        static logic [15:0] tbl [4] = '{16'hfffd, 16'h0000, 16'hffdd, 16'hfbfd};
        foreach (tbl[i]) begin
            boot({3'b111, tbl[i]});
            check(seenV, expect_of({3'b111, tbl[i]}));
        end
    endtask
    task t_narrow;
        boot({3'b001, 16'hd2f2});
        check(seenV, expect_of({3'b001, 16'hd2f2}));
        repeat (8) @(posedge core_clk);
        #1 check(seenV, expect_of({3'b001, 16'hd2f2}));
    endtask
    // write held in reset is refused, then two writes land back to back
    task t_swwrite;
        @(posedge core_clk);
        swPortEWr <= 1'b1;
        swPortEData <= 8'h5a;
        boot({3'b101, 16'hfffd});
        check({23'h0, portEAssign, portFAssign}, 39'h0);
        @(posedge core_clk);
        swPortEWr <= 1'b0;
        swPortFWr <= 1'b1;
        swPortFData <= 8'hc3;
        @(posedge core_clk);
        swPortFWr <= 1'b0;
        #1 check({23'h0, portEAssign, portFAssign}, 39'h5ac3);
    endtask
    task close_out;
        if (failures == 0 && checkCount > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        rst_b = 1'b0;
        strap = 19'h0;
        {swPortEWr, swPortFWr, swPortEData, swPortFData} = 18'h0;
        t_single;
        t_wide;
        t_narrow;
        t_swwrite;
        close_out;
    end
    // cut a hang well past the 46 or so cycles the run needs
    initial begin
        #20000;
        failures++;
        close_out;
    end
endmodule
